//--- src/cee_exc_unit.sv
// Implementation choice: the Wishbone register port.
`timescale 1ns/100ps
`include "cee_map.svh"

// Operation
// RQ1: reset aborts, initializes, jumps to reset vector
// RQ2: entry saves pc and status word
// RQ3: any reset or entry sets block bit
// RQ4: entry sets bank select bit
// RQ5: event code into exception or interrupt register
// RQ6: trap immediate loads bits 9 to 2
// RQ7: ordered entry ends in jump, no nesting; with multi set, entries are also accepted in ST_JUMP
// RQ8: return restores status, runs slot, branches
// RQ9: nothing accepted during return; saved regs writable
// RQ10: vector is base plus general or interrupt offset
// RQ11: trap register writes only bits 9 to 2
// RQ12: exception code writes bits 11 to 0 only
// RQ13: codes init 000 power-on, 020 manual
// RQ14: interrupt code register written by hardware only
// RQ15: interrupts wait while block bit set
// RQ16: low power accepts interrupt and wakes
// RQ17: dma address error held until block clears
// RQ18: user breaks under block bit are dropped
// RQ19: other exception under block jumps reset-like
// RQ20: handler saves state before clearing block bit
// RQ21: reset first, interrupt only without exceptions
// RQ22: re-execution saves current, completion next address
module cee_exc_unit
    import cee_pkg::*;
#(
    parameter int AW = 32
)
(
    // clock and reset
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst,
    // reset requests
    input  wire logic         i_por_req,
    input  wire logic         i_man_req,
    // pipeline requests
    input  wire cee_exc_req_t i_exc,
    input  wire cee_int_req_t i_int,
    input  wire logic         i_low_power,
    input  wire logic [31:0]  i_pc,
    input  wire logic [31:0]  i_next_pc,
    input  wire logic         i_rte,
    input  wire logic         i_slot_done,
    // pipeline control
    output logic              o_redirect,
    output logic [31:0]       o_target,
    output logic              o_abort,
    output logic              o_exc_ack,
    output logic              o_int_ack,
    output logic              o_wake,
    output logic              o_slot_go,
    output logic              o_busy,
    output logic [31:0]       o_status_word,
    // wishbone slave
    input  wire logic         i_wb_cyc,
    input  wire logic         i_wb_stb,
    input  wire logic         i_wb_we,
    input  wire logic [AW-1:0] i_wb_adr,
    input  wire logic [3:0]   i_wb_sel,
    input  wire logic [31:0]  i_wb_dat,
    output logic [31:0]       o_wb_dat,
    output logic              o_wb_ack
);

    function automatic logic [31:0] cee_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [31:0] mask
    );
        cee_merge = (old_v & ~mask) | (new_v & mask);
    endfunction : cee_merge

    cee_state_t  st_q;
    cee_state_t  st_d;
    logic [31:0] sw_q;
    logic [31:0] sw_d;
    logic [31:0] ssw_q;
    logic [31:0] ssw_d;
    logic [31:0] spc_q;
    logic [31:0] spc_d;
    logic [31:0] vbr_q;
    logic [31:0] vbr_d;
    logic [31:0] tgt_q;
    logic [31:0] tgt_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic [7:0]  tra_q;
    logic [7:0]  tra_d;
    logic [11:0] ecode_q;
    logic [11:0] ecode_d;
    logic [11:0] icode_q;
    logic [11:0] icode_d;
    logic [11:0] dcode_q;
    logic [11:0] dcode_d;
    logic        dpend_q;
    logic        dpend_d;
    logic        multi_q;
    logic        multi_d;
    logic        ack_q;
    logic        ack_d;

    // acceptance decode
    wire logic bl      = sw_q[`CEE_SW_BL_BIT];
    wire logic idle    = (st_q == ST_IDLE);
    wire logic win     = idle | (multi_q & (st_q == ST_JUMP)); // see RQ7
    wire logic rst_go  = i_por_req | i_man_req; // see RQ1
    wire logic gen_v   = i_exc.valid;
    wire logic k_trap  = (i_exc.kind == CEE_KIND_TRAP);
    wire logic k_ubrk  = (i_exc.kind == CEE_KIND_UBRK);
    wire logic k_dma   = (i_exc.kind == CEE_KIND_DMA);
    wire logic gen_go  = win & ~rst_go & gen_v & ~bl; // see RQ21
    // see RQ18 see RQ19
    wire logic dbl_go  = win & ~rst_go & gen_v & bl & ~k_ubrk & ~k_dma;
    // see RQ17
    wire logic pend_go = win & ~rst_go & ~gen_v & dpend_q & ~bl;
    wire logic int_ok  = ~bl | i_low_power; // see RQ15 see RQ16
    // see RQ21
    wire logic int_go  = win & ~rst_go & ~gen_v & ~pend_go & i_int.valid & int_ok;
    wire logic ent_go  = gen_go | pend_go | int_go;
    wire logic rte_go  = idle & i_rte & ~rst_go & ~ent_go & ~dbl_go;
    wire logic dp_set  = gen_v & k_dma & bl; // see RQ17
    wire logic reexec  = gen_go & i_exc.reexec;
    wire logic [31:0] voff = int_go ? `CEE_VOFF_INT : `CEE_VOFF_GEN;

    // bus decode
    wire logic        req      = i_wb_cyc & i_wb_stb;
    wire logic        wr       = req & i_wb_we & ack_q;
    wire logic        hit_tra  = (i_wb_adr == `CEE_OFF_TRAP_IMM);
    wire logic        hit_ec   = (i_wb_adr == `CEE_OFF_EXC_CODE);
    wire logic        hit_ic   = (i_wb_adr == `CEE_OFF_INT_CODE);
    wire logic        hit_sw   = (i_wb_adr == `CEE_OFF_STATUS);
    wire logic        hit_spc  = (i_wb_adr == `CEE_OFF_SAVED_PC);
    wire logic        hit_ssw  = (i_wb_adr == `CEE_OFF_SAVED_SW);
    wire logic        hit_vbr  = (i_wb_adr == `CEE_OFF_VBR);
    wire logic        hit_ctl  = (i_wb_adr == `CEE_OFF_CTRL);
    wire logic [31:0] wm       = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                                  {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    wire logic [31:0] tra_word = {22'h000000, tra_q, 2'h0};
    wire logic [31:0] ec_word  = {20'h00000, ecode_q};
    wire logic [31:0] ic_word  = {20'h00000, icode_q};
    wire logic [31:0] ctl_word = {31'h00000000, multi_q};
    wire logic [31:0] tra_new  = cee_merge(tra_word, i_wb_dat, wm);
    wire logic [31:0] ec_new   = cee_merge(ec_word, i_wb_dat, wm);
    wire logic [31:0] rd_mux   = hit_tra ? tra_word :
                                 hit_ec  ? ec_word  :
                                 hit_ic  ? ic_word  :
                                 hit_sw  ? sw_q     :
                                 hit_spc ? spc_q    :
                                 hit_ssw ? ssw_q    :
                                 hit_vbr ? vbr_q    :
                                 hit_ctl ? ctl_word :
                                 32'h00000000;

    // sequencer
    always_comb
    begin
        st_d = st_q;
        if (rst_go | dbl_go | ent_go)
        begin
            st_d = ST_JUMP; // see RQ7
        end
        else
        begin
            unique case (st_q)
                ST_IDLE:
                begin
                    if (rte_go)
                    begin
                        st_d = ST_RTE_SW; // see RQ8
                    end
                end
                ST_JUMP:
                begin
                    st_d = ST_IDLE;
                end
                ST_RTE_SW:
                begin
                    st_d = ST_RTE_SLOT; // see RQ8
                end
                ST_RTE_SLOT:
                begin
                    if (i_slot_done)
                    begin
                        st_d = ST_RTE_BR; // see RQ8
                    end
                end
                ST_RTE_BR:
                begin
                    st_d = ST_IDLE;
                end
                default:
                begin
                    st_d = ST_IDLE;
                end
            endcase
        end
    end

    // status word and saved copies
    always_comb
    begin
        sw_d  = sw_q;
        ssw_d = ssw_q;
        spc_d = spc_q;
        vbr_d = vbr_q;
        if (rst_go | dbl_go)
        begin
            sw_d = `CEE_SW_RESET; // see RQ1 see RQ3 see RQ19
        end
        else if (ent_go)
        begin
            sw_d[`CEE_SW_BL_BIT] = 1'b1; // see RQ3
            sw_d[`CEE_SW_RB_BIT] = 1'b1; // see RQ4
        end
        else if (st_q == ST_RTE_SW)
        begin
            sw_d = ssw_q; // see RQ8
        end
        else if (wr & hit_sw)
        begin
            sw_d = cee_merge(sw_q, i_wb_dat, wm);
        end
        if (ent_go)
        begin
            ssw_d = sw_q; // see RQ2
            spc_d = reexec ? i_pc : i_next_pc; // see RQ2 see RQ22
        end
        else
        begin
            if (wr & hit_ssw)
            begin
                ssw_d = cee_merge(ssw_q, i_wb_dat, wm); // see RQ9
            end
            if (wr & hit_spc)
            begin
                spc_d = cee_merge(spc_q, i_wb_dat, wm); // see RQ9
            end
        end
        if (rst_go)
        begin
            vbr_d = `CEE_VBR_RESET; // see RQ1
        end
        else if (wr & hit_vbr)
        begin
            vbr_d = cee_merge(vbr_q, i_wb_dat, wm);
        end
    end

    // jump target
    always_comb
    begin
        tgt_d = tgt_q;
        if (rst_go | dbl_go)
        begin
            tgt_d = `CEE_VEC_RESET; // see RQ1 see RQ19
        end
        else if (ent_go)
        begin
            tgt_d = vbr_q + voff; // see RQ10
        end
        else if (st_q == ST_RTE_SW)
        begin
            tgt_d = spc_q; // see RQ8
        end
    end

    // event codes and trap immediate
    always_comb
    begin
        ecode_d = ecode_q;
        icode_d = icode_q;
        tra_d   = tra_q;
        if (i_por_req)
        begin
            ecode_d = `CEE_CODE_POR; // see RQ13
            icode_d = `CEE_CODE_POR; // see RQ13
        end
        else if (i_man_req)
        begin
            ecode_d = `CEE_CODE_MAN; // see RQ13
            icode_d = `CEE_CODE_MAN; // see RQ13
        end
        else if (gen_go)
        begin
            ecode_d = i_exc.code; // see RQ5
        end
        else if (pend_go)
        begin
            ecode_d = dcode_q; // see RQ5
        end
        else if (int_go)
        begin
            icode_d = i_int.code; // see RQ5 see RQ14
        end
        else if (wr & hit_ec)
        begin
            ecode_d = ec_new[`CEE_CODE_MSB:0]; // see RQ12
        end
        if (gen_go & k_trap)
        begin
            tra_d = i_exc.imm; // see RQ6
        end
        else if (wr & hit_tra)
        begin
            tra_d = tra_new[`CEE_TRA_MSB:`CEE_TRA_LSB]; // see RQ11
        end
    end

    // pending dma error, control, bus answer
    always_comb
    begin
        dpend_d = dpend_q;
        dcode_d = dcode_q;
        multi_d = multi_q;
        if (rst_go)
        begin
            dpend_d = 1'b0;
        end
        else if (dp_set)
        begin
            dpend_d = 1'b1; // see RQ17
            dcode_d = i_exc.code;
        end
        else if (pend_go)
        begin
            dpend_d = 1'b0;
        end
        if (rst_go)
        begin
            multi_d = 1'b0;
        end
        else if (wr & hit_ctl & i_wb_sel[0])
        begin
            multi_d = i_wb_dat[`CEE_CTRL_MULTI];
        end
        ack_d  = req & ~ack_q;
        rdat_d = (req & ~ack_q) ? rd_mux : rdat_q;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_q    <= ST_IDLE;
            sw_q    <= `CEE_SW_RESET;
            ssw_q   <= 32'h00000000;
            spc_q   <= 32'h00000000;
            vbr_q   <= `CEE_VBR_RESET;
            tgt_q   <= `CEE_VEC_RESET;
            tra_q   <= 8'h00;
            ecode_q <= `CEE_CODE_POR;
            icode_q <= `CEE_CODE_POR;
            dcode_q <= 12'h000;
            dpend_q <= 1'b0;
            multi_q <= 1'b0;
            ack_q   <= 1'b0;
            rdat_q  <= 32'h00000000;
        end
        else
        begin
            st_q    <= st_d;
            sw_q    <= sw_d;
            ssw_q   <= ssw_d;
            spc_q   <= spc_d;
            vbr_q   <= vbr_d;
            tgt_q   <= tgt_d;
            tra_q   <= tra_d;
            ecode_q <= ecode_d;
            icode_q <= icode_d;
            dcode_q <= dcode_d;
            dpend_q <= dpend_d;
            multi_q <= multi_d;
            ack_q   <= ack_d;
            rdat_q  <= rdat_d;
        end
    end

    // pipeline outputs
    assign o_redirect    = (st_q == ST_JUMP) | (st_q == ST_RTE_BR); // see RQ7 see RQ8
    assign o_target      = tgt_q;
    assign o_abort       = rst_go | dbl_go | reexec; // see RQ1 see RQ22
    assign o_exc_ack     = gen_go | pend_go | dbl_go;
    assign o_int_ack     = int_go;
    assign o_wake        = int_go & i_low_power; // see RQ16
    assign o_slot_go     = (st_q == ST_RTE_SLOT); // see RQ8
    assign o_busy        = ~idle; // see RQ9
    assign o_status_word = sw_q;
    assign o_wb_dat      = rdat_q;
    assign o_wb_ack      = ack_q;

endmodule : cee_exc_unit

//--- src/cee_map.svh
`ifndef CEE_MAP_SVH
`define CEE_MAP_SVH
// register byte addresses
`define CEE_OFF_TRAP_IMM  32'h0FFFFFD0
`define CEE_OFF_EXC_CODE  32'h0FFFFFD4
`define CEE_OFF_INT_CODE  32'hA4000000
`define CEE_OFF_STATUS    32'h0FFFFFE0
`define CEE_OFF_SAVED_PC  32'h0FFFFFE4
`define CEE_OFF_SAVED_SW  32'h0FFFFFE8
`define CEE_OFF_VBR       32'h0FFFFFEC
`define CEE_OFF_CTRL      32'h0FFFFFF0
// status word fields
`define CEE_SW_BL_BIT     28
`define CEE_SW_RB_BIT     29
`define CEE_SW_RESET      32'h30000000
// field positions
`define CEE_TRA_MSB       9
`define CEE_TRA_LSB       2
`define CEE_CODE_MSB      11
`define CEE_CTRL_MULTI    0
// reset values and vectors
`define CEE_CODE_POR      12'h000
`define CEE_CODE_MAN      12'h020
`define CEE_VBR_RESET     32'h00000000
`define CEE_VEC_RESET     32'hA0000000
`define CEE_VOFF_GEN      32'h00000100
`define CEE_VOFF_INT      32'h00000600
`endif

//--- src/cee_pkg.sv
package cee_pkg;

    typedef enum logic [1:0] {
        CEE_KIND_OTHER = 2'h0,
        CEE_KIND_TRAP  = 2'h1,
        CEE_KIND_UBRK  = 2'h2,
        CEE_KIND_DMA   = 2'h3
    } cee_kind_t;

    typedef struct packed {
        logic        valid;
        cee_kind_t   kind;
        logic        reexec;
        logic [11:0] code;
        logic [7:0]  imm;
    } cee_exc_req_t;

    typedef struct packed {
        logic        valid;
        logic [11:0] code;
    } cee_int_req_t;

    typedef enum logic [4:0] {
        ST_IDLE     = 5'h01,
        ST_JUMP     = 5'h02,
        ST_RTE_SW   = 5'h04,
        ST_RTE_SLOT = 5'h08,
        ST_RTE_BR   = 5'h10
    } cee_state_t;

endpackage : cee_pkg

//--- verification/cee_exc_props.sv
`timescale 1ns/100ps
`include "cee_map.svh"
module cee_exc_props
    import cee_pkg::*;
(
    // watched ports
    input wire logic         i_ref_clk,
    input wire logic         i_rst,
    input wire logic         i_por_req,
    input wire logic         i_man_req,
    input wire cee_exc_req_t i_exc,
    input wire cee_int_req_t i_int,
    input wire logic         i_low_power,
    input wire logic         i_rte,
    input wire logic         i_slot_done,
    input wire logic         i_wb_cyc,
    input wire logic         i_wb_stb,
    input wire logic         o_redirect,
    input wire logic [31:0]  o_target,
    input wire logic         o_abort,
    input wire logic         o_exc_ack,
    input wire logic         o_int_ack,
    input wire logic         o_wake,
    input wire logic         o_slot_go,
    input wire logic         o_busy,
    input wire logic [31:0]  o_status_word,
    input wire logic         o_wb_ack
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    wire blk = o_status_word[`CEE_SW_BL_BIT];

    sequence reset_jump;
        o_abort ##1 (o_redirect && o_target == `CEE_VEC_RESET);
    endsequence
    sequence ret_run;
        (o_busy && !o_slot_go) ##1 o_slot_go;
    endsequence

    wb_ack_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
        else $error("bus ack not a single cycle after request");
    reset_jump_a: assert property (i_por_req || i_man_req |-> reset_jump)
        else $error("reset did not jump to reset vector");
    entry_bits_a: assert property (o_exc_ack || o_int_ack |=> o_redirect && blk && o_status_word[`CEE_SW_RB_BIT])
        else $error("entry without block and bank bits");
    int_hold_a: assert property (i_int.valid && blk && !i_low_power |-> !o_int_ack)
        else $error("interrupt taken under block bit");
    wake_up_a: assert property (o_wake == (o_int_ack && i_low_power))
        else $error("no wake with low power interrupt");
    int_prio_a: assert property (i_por_req || i_man_req || (i_exc.valid && !blk && !o_busy) |-> !o_int_ack)
        else $error("interrupt beat a higher request");
    ubrk_drop_a: assert property (i_exc.valid && i_exc.kind == CEE_KIND_UBRK && blk |-> !o_exc_ack)
        else $error("user break taken under block bit");
    reexec_abort_a: assert property (o_exc_ack && i_exc.valid && i_exc.reexec |-> o_abort)
        else $error("re-execution entry did not abort");
    ret_seq_a: assert property (!o_busy && i_rte && !o_exc_ack && !o_int_ack && !o_abort |=> ret_run)
        else $error("return steps out of order");
    slot_end_a: assert property (o_slot_go && i_slot_done |=> o_redirect && !o_slot_go)
        else $error("no branch after delay slot");
    ret_quiet_a: assert property (o_slot_go |-> !o_exc_ack && !o_int_ack)
        else $error("request taken during return");
endmodule : cee_exc_props

bind cee_exc_unit cee_exc_props chk_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_por_req(i_por_req),
    .i_man_req(i_man_req), .i_exc(i_exc), .i_int(i_int), .i_low_power(i_low_power), .i_rte(i_rte),
    .i_slot_done(i_slot_done), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_redirect(o_redirect),
    .o_target(o_target), .o_abort(o_abort), .o_exc_ack(o_exc_ack), .o_int_ack(o_int_ack), .o_wake(o_wake),
    .o_slot_go(o_slot_go), .o_busy(o_busy), .o_status_word(o_status_word), .o_wb_ack(o_wb_ack));

//--- verification/cee_exc_unit_tb.sv
`timescale 1ns/100ps
`include "cee_map.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (g), (e)); end end
module cee_exc_unit_tb;
    import cee_pkg::*;
    logic         clk = 0, rst = 1, por = 0, man = 0, lowp = 0, ret_req = 0, slot_done;
    logic         cyc = 0, stb = 0, we = 0, redir, abort_s, eack, iack, wake, sgo, busy, ack;
    logic [31:0]  pc = 0, np = 0, vbase = 0, adr = 0, wdat = 0, rdat, target, sw;
    logic [1:0]   lag = 0;
    logic [7:0]   imm = 0;
    logic [3:0]   sel = 4'hF, wsel = 4'hF;
    cee_exc_req_t exc = '0;
    cee_int_req_t irq = '0;
    int           bad_count = 0, tests_run = 0;
    logic [31:0]  rd_q[$], tg_q[$];

    always #4 clk = ~clk;

    cee_exc_unit dut_u (.i_ref_clk(clk), .i_rst(rst), .i_por_req(por), .i_man_req(man), .i_exc(exc),
        .i_int(irq), .i_low_power(lowp), .i_pc(pc), .i_next_pc(np), .i_rte(ret_req), .i_slot_done(slot_done),
        .o_redirect(redir), .o_target(target), .o_abort(abort_s), .o_exc_ack(eack), .o_int_ack(iack),
        .o_wake(wake), .o_slot_go(sgo), .o_busy(busy), .o_status_word(sw), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack));
    cee_pipe_model pipe_u (.i_ref_clk(clk), .i_slot_go(sgo), .i_lag(lag), .o_slot_done(slot_done));

    // requests drop once taken
    always @(posedge clk)
    begin
        if (eack === 1'b1)
            exc.valid <= 1'b0;
        if (iack === 1'b1)
            irq.valid <= 1'b0;
    end

    // result monitor
    always @(posedge clk)
    begin
        if (ack === 1'b1 && we === 1'b0)
        begin
            `CHK(rdat, rd_q[0])
            void'(rd_q.pop_front());
        end
        if (redir === 1'b1 && tg_q.size() > 0)
        begin
            `CHK(target, tg_q[0])
            void'(tg_q.pop_front());
        end
    end

    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= wsel;
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask : rd

    task automatic redir_wait(input logic [31:0] t);
        tg_q.push_back(t);
        do @(posedge clk); while (redir !== 1'b1);
    endtask : redir_wait

    task automatic do_ret(input logic [31:0] t);
        @(posedge clk);
        ret_req <= 1'b1;
        @(posedge clk);
        ret_req <= 1'b0;
        redir_wait(t);
    endtask : do_ret

    task automatic end_of_test;
        if (rd_q.size() != 0 || tg_q.size() != 0)
            bad_count++;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    initial
    begin
        repeat (5000) @(posedge clk);
        bad_count++;
        end_of_test();
    end

    initial
    begin
        void'($urandom(88));
        np = $urandom & 32'hFFFFFFFE;
        pc = $urandom & 32'hFFFFFFFE;
        vbase = $urandom & 32'hFFFFF000;
        imm = $urandom;
        lag = $urandom;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(`CEE_OFF_STATUS, `CEE_SW_RESET);
        rd(`CEE_OFF_INT_CODE, 32'h0);
        rd(32'h0FFFFF00, 32'h0);
        wb(1'b1, `CEE_OFF_TRAP_IMM, 32'hFFFFFFFF);
        rd(`CEE_OFF_TRAP_IMM, 32'h000003FC);
        wb(1'b1, `CEE_OFF_EXC_CODE, 32'hFFFFFFFF);
        rd(`CEE_OFF_EXC_CODE, 32'h00000FFF);
        wsel = 4'h1;
        wb(1'b1, `CEE_OFF_EXC_CODE, 32'h00000ABC);
        wsel = 4'hF;
        rd(`CEE_OFF_EXC_CODE, 32'h00000FBC);
        wb(1'b1, `CEE_OFF_INT_CODE, 32'hFFFFFFFF);
        rd(`CEE_OFF_INT_CODE, 32'h0);
        wb(1'b1, `CEE_OFF_VBR, vbase);
        wb(1'b1, `CEE_OFF_STATUS, 32'h0);
        // trap entry, completion type
        exc <= '{1'b1, CEE_KIND_TRAP, 1'b0, 12'h160, imm};
        redir_wait(vbase + `CEE_VOFF_GEN);
        rd(`CEE_OFF_SAVED_PC, np);
        rd(`CEE_OFF_SAVED_SW, 32'h0);
        rd(`CEE_OFF_STATUS, 32'h30000000);
        rd(`CEE_OFF_TRAP_IMM, {22'h0, imm, 2'h0});
        rd(`CEE_OFF_EXC_CODE, 32'h00000160);
        // requests under the block bit
        irq <= '{1'b1, 12'h3A0};
        exc <= '{1'b1, CEE_KIND_UBRK, 1'b1, 12'h1E0, 8'h0};
        repeat (3) @(posedge clk);
        exc <= '{1'b1, CEE_KIND_DMA, 1'b0, 12'h5C0, 8'h0};
        repeat (2) @(posedge clk);
        exc.valid <= 1'b0;
        do_ret(np);
        redir_wait(vbase + `CEE_VOFF_GEN);
        rd(`CEE_OFF_EXC_CODE, 32'h000005C0);
        do_ret(np);
        redir_wait(vbase + `CEE_VOFF_INT);
        rd(`CEE_OFF_INT_CODE, 32'h000003A0);
        // double fault, then manual reset, then low power wake
        exc <= '{1'b1, CEE_KIND_OTHER, 1'b1, 12'h180, 8'h0};
        redir_wait(`CEE_VEC_RESET);
        rd(`CEE_OFF_STATUS, `CEE_SW_RESET);
        man <= 1'b1;
        @(posedge clk);
        man <= 1'b0;
        redir_wait(`CEE_VEC_RESET);
        rd(`CEE_OFF_EXC_CODE, 32'h00000020);
        lowp <= 1'b1;
        irq <= '{1'b1, 12'h400};
        redir_wait(`CEE_VOFF_INT);
        lowp <= 1'b0;
        rd(`CEE_OFF_INT_CODE, 32'h00000400);
        // re-execution entry saves the current address
        wb(1'b1, `CEE_OFF_STATUS, 32'h0);
        exc <= '{1'b1, CEE_KIND_OTHER, 1'b1, 12'h0E0, 8'h0};
        redir_wait(`CEE_VOFF_GEN);
        rd(`CEE_OFF_SAVED_PC, pc);
        repeat (2) @(posedge clk);
        end_of_test();
    end
endmodule : cee_exc_unit_tb

//--- verification/cee_pipe_model.sv
`timescale 1ns/100ps
module cee_pipe_model
(
    // clock
    input  wire logic       i_ref_clk,
    // return delay slot
    input  wire logic       i_slot_go,
    input  wire logic [1:0] i_lag,
    output logic            o_slot_done
);
    logic [1:0] wait_q = 2'h0;

    initial o_slot_done = 1'b0;

    // slot instruction finishes i_lag + 1 cycles after it is started
    always @(posedge i_ref_clk)
    begin
        o_slot_done <= 1'b0;
        if (i_slot_go && !o_slot_done && wait_q == i_lag)
        begin
            o_slot_done <= 1'b1;
            wait_q      <= 2'h0;
        end
        else if (i_slot_go && !o_slot_done)
            wait_q <= wait_q + 2'h1;
    end
endmodule : cee_pipe_model
